// ===== bench/pcr_assertions.sv
// link checks for both ends of the configuration link.
// assumes the host's default half period of 4 core cycles.
`timescale 1ns/10ps
module pcr_assertions (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        config_clock,
    input wire logic [31:0] data,
    input wire logic        reconfig_req_n,
    input wire logic        status_n,
    input wire logic        cfg_done,
    input wire logic        init_complete
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_por_lines_low: assert property (
        $fell(sys_rst) |-> (!status_n && !cfg_done) [*8]) else $error("por lines");
    a_done_clean: assert property (
        $rose(cfg_done) |-> status_n) else $error("done on error");
    a_abort_done: assert property (
        $fell(reconfig_req_n) |-> ##[1:8] !cfg_done) else $error("abort");
    a_init_in_load: assert property (
        $fell(init_complete) |-> !cfg_done) else $error("init");
    a_data_clk_low: assert property (
        !$stable(data) |-> !config_clock) else $error("data edge");
    a_falls_after_done: assert property (
        $rose(cfg_done) |-> ##[1:60] $fell(config_clock)) else $error("falls");
    a_reconf_hold: assert property (
        $fell(reconfig_req_n) |=> !reconfig_req_n [*8]) else $error("request");
    a_clk_high_len: assert property (
        $rose(config_clock) |=> config_clock [*3] ##1 !config_clock) else $error("high");
endmodule // pcr_assertions

// ===== bench/tb_top.sv
// bench: host and device joined over the link; every mode, then a bad image, then one more good run.
// assumes both ends share IMAGE_WORDS and mode inputs.
`timescale 1ns/10ps
module tb_top;
    import pcr_pkg::*;
    localparam int NW = 4;
    logic core_clk = 0, sys_rst = 1, start = 0, pause = 0, decomp_en = 0, security_en = 0;
    pcr_width_type width_sel = PCR_W8;
    logic [31:0] img [NW], cap [NW], word_in, word_data;
    logic [$clog2(NW+1)-1:0] word_index;
    logic word_valid, user_mode, cfg_error, busy, finished, failed;
    int mismatches = 0, cmp_count = 0, nw = 0, rises = 0;
    pcr_link_if link ();
    pcr_host #(.IMAGE_WORDS(NW)) pcr_host_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
        .width_sel(width_sel), .decomp_en(decomp_en), .security_en(security_en), .start(start), .pause(pause),
        .word_in(word_in), .word_index(word_index), .busy(busy), .finished(finished), .failed(failed));
    pcr_device #(.IMAGE_WORDS(NW)) pcr_device_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
        .width_sel(width_sel), .decomp_en(decomp_en), .security_en(security_en), .word_data(word_data),
        .word_valid(word_valid), .user_mode(user_mode), .cfg_error(cfg_error));
    pcr_assertions pcr_assertions_inst (.core_clk(core_clk), .sys_rst(sys_rst), .config_clock(link.config_clock),
        .data(link.data), .reconfig_req_n(link.reconfig_req_n), .status_n(link.status_n),
        .cfg_done(link.cfg_done), .init_complete(link.init_complete));
    assign word_in = img[word_index[1:0]];
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (word_valid) begin
        cap[nw[1:0]] <= word_data;
        nw <= nw + 1;
    end
    always @(posedge link.config_clock) if (!link.cfg_done) rises++;
    function automatic int exp_ratio(pcr_width_type w, logic d, logic s);
        return (w != PCR_W32) ? 1 : d ? 8 : s ? 4 : 1;
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // narrow modes get random decompress/security bits: their ratio must stay 1
    task automatic run(int mode, logic bad);
        logic [31:0] m;
        int n0, r0;
        @(posedge core_clk);
        width_sel <= mode < 2 ? pcr_width_type'(mode) : PCR_W32;
        {decomp_en, security_en} <= mode < 2 ? 2'($urandom) : 2'(mode - 2);
        for (int i = 0; i < NW; i++) img[i] <= $urandom;
        img[0] <= bad ? ~SYNC_WORD : SYNC_WORD;
        img[1][0] <= 1'b1;
        n0 = nw;
        r0 = rises;
        @(posedge core_clk) start <= 1;
        @(posedge core_clk) start <= 0;
        m = width_sel == PCR_W8 ? 32'h0000_00ff : width_sel == PCR_W16 ? 32'h0000_ffff : 32'hffff_ffff;
        repeat (2) @(posedge core_clk);
        for (int t = 0; t < 5000 && !(finished || failed); t++) @(posedge core_clk) pause <= $urandom % 16 == 0;
        pause <= 0;
        repeat (8) @(posedge core_clk);
        chk("ended", 1, finished | failed);
        chk("busy", 0, busy);
        chk("lanes", 32'h0, link.data & ~m);
        chk("failed", bad, failed);
        chk("cfg_error", bad, cfg_error);
        chk("status", !bad, link.status_n);
        if (!bad) begin
            chk("rises", exp_ratio(width_sel, decomp_en, security_en) * NW, rises - r0);
            chk("words", NW, nw - n0);
            chk("done", 1, link.cfg_done);
            chk("user_mode", 1, user_mode);
            chk("init", 1, link.init_complete);
            for (int i = 0; i < NW; i++) chk("word", img[i] & m, cap[(n0 + i) % NW]);
        end
    endtask
    initial begin
        void'($urandom(6149));
        repeat (20) @(posedge core_clk);
        sys_rst <= 0;
        for (int t = 0; t < 3000 && link.status_n !== 1'b1; t++) @(posedge core_clk);
        chk("status", 1, link.status_n);
        for (int k = 0; k < 8; k++) run(k % 6, k == 6);
        finish_test();
    end
    // about 4000 cycles expected; ten times that is a hang
    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end
endmodule // tb_top

// ===== verilog/pcr_device.sv
// device end of the fast_passive_parallel_load link: samples the host's
// config_clock and data, reports progress on open-drain lines.
// assumes the link pins are asynchronous to core_clk and the link clock
// runs well below a quarter of core_clk.
`timescale 1ns/10ps
module pcr_device #(
    parameter int IMAGE_WORDS = 16
) (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    pcr_link_if.device                  link,
    input  wire pcr_pkg::pcr_width_type width_sel,
    input  wire logic                   decomp_en,
    input  wire logic                   security_en,
    output logic [31:0]                 word_data,
    output logic                        word_valid,
    output logic                        user_mode,
    output logic                        cfg_error
);
    import pcr_pkg::*;

    localparam int CW = $clog2(IMAGE_WORDS + 1);

    typedef enum logic [2:0] {ST_POR, ST_CLEAR, ST_LOAD, ST_ERROR, ST_INIT, ST_USER} pcr_dev_state_type;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0]  config_clock_sync_reg;
    logic        config_clock_hist_reg;
    logic [1:0]  ncfg_sync_reg;
    logic [31:0] data_meta_reg;
    logic [31:0] data_sync_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            config_clock_sync_reg <= 2'h0;
            config_clock_hist_reg <= 1'b0;
            ncfg_sync_reg <= 2'h3;
            data_meta_reg <= 32'h0000_0000;
            data_sync_reg <= 32'h0000_0000;
        end else begin
            config_clock_sync_reg <= {config_clock_sync_reg[0], link.config_clock};
            config_clock_hist_reg <= config_clock_sync_reg[1];
            ncfg_sync_reg <= {ncfg_sync_reg[0], link.reconfig_req_n};
            data_meta_reg <= link.data;
            data_sync_reg <= data_meta_reg;
        end
    end

    // data is stable before the rising edge, so the synchronised word is
    // taken in the same cycle the synchronised edge shows up
    wire config_clock_rise = config_clock_sync_reg[1] & ~config_clock_hist_reg;
    wire config_clock_fall = ~config_clock_sync_reg[1] & config_clock_hist_reg;
    wire ncfg_low  = ~ncfg_sync_reg[1];

    // ****************************************************************
    // state
    // ****************************************************************
    pcr_dev_state_type state_reg, state_next;
    logic [$clog2(POR_CYCLES)-1:0] por_cnt_reg, por_cnt_next;
    logic [3:0]  ratio_reg, ratio_next;
    logic [31:0] mask_reg, mask_next;
    logic [3:0]  phase_reg, phase_next;
    logic [CW-1:0] word_cnt_reg, word_cnt_next;
    logic [1:0]  fall_cnt_reg, fall_cnt_next;
    logic        init_opt_reg, init_opt_next;
    logic        status_drive_reg, status_drive_next;
    logic        done_drive_reg, done_drive_next;
    logic        init_drive_reg, init_drive_next;
    logic [31:0] word_data_reg, word_data_next;
    logic        word_valid_reg, word_valid_next;
    logic        user_mode_reg, user_mode_next;
    logic        error_reg, error_next;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire           in_load     = (state_reg == ST_LOAD);
    wire           group_start = (phase_reg == 4'h0);
    wire           phase_wrap  = (phase_reg == ratio_reg - 4'h1);
    wire [3:0]     phase_step  = phase_wrap ? 4'h0 : phase_reg + 4'h1;
    wire           capture     = in_load & config_clock_rise & group_start
                                 & (word_cnt_reg != CW'(IMAGE_WORDS)); // [R15]
    wire [31:0]    captured    = data_sync_reg & mask_reg;
    wire [CW-1:0]  words_after = word_cnt_reg + CW'(capture);
    wire           is_sync_idx = (word_cnt_reg == CW'(SYNC_WORD_IDX));
    wire           is_opt_idx  = (word_cnt_reg == CW'(OPTION_WORD_IDX));
    wire           sync_bad    = capture & is_sync_idx & (captured != (SYNC_WORD & mask_reg));
    // the last word's group must run out before done is released, which
    // uses the ratio-1 trailing clocks the host keeps sending
    wire           image_end   = (words_after == CW'(IMAGE_WORDS)) & (phase_step == 4'h0);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next        = state_reg;
        por_cnt_next      = por_cnt_reg;
        ratio_next        = ratio_reg;
        mask_next         = mask_reg;
        phase_next        = phase_reg;
        word_cnt_next     = word_cnt_reg;
        fall_cnt_next     = fall_cnt_reg;
        init_opt_next     = init_opt_reg;
        status_drive_next = status_drive_reg;
        done_drive_next   = done_drive_reg;
        init_drive_next   = init_drive_reg;
        word_data_next    = capture ? captured : word_data_reg;
        word_valid_next   = capture;
        user_mode_next    = user_mode_reg;
        error_next        = error_reg;
        case (state_reg)
            ST_POR: begin
                status_drive_next = 1'b1;                              // [R6]
                done_drive_next   = 1'b1;                              // [R7]
                if (por_cnt_reg == ($clog2(POR_CYCLES))'(POR_CYCLES - 1)) begin
                    state_next = ST_CLEAR;
                end else begin
                    por_cnt_next = por_cnt_reg + 1'b1;
                end
            end
            ST_CLEAR: begin
                status_drive_next = 1'b1;
                done_drive_next   = 1'b1;                              // [R7]
                init_drive_next   = 1'b0;
                init_opt_next     = 1'b0;
                user_mode_next    = 1'b0;
                error_next        = 1'b0;
                ratio_next        = ratio_of(width_sel, decomp_en, security_en); // [R1]
                mask_next         = lane_mask(width_sel);
                phase_next        = 4'h0;
                word_cnt_next     = '0;
                fall_cnt_next     = 2'h0;
                if (!ncfg_low) begin
                    state_next        = ST_LOAD;
                    status_drive_next = 1'b0;
                end
            end
            ST_LOAD: begin
                if (config_clock_rise) begin
                    phase_next    = phase_step;                        // [R1]
                    word_cnt_next = words_after;
                    if (capture && is_opt_idx) begin
                        init_opt_next   = captured[OPTION_INIT_BIT];
                        init_drive_next = captured[OPTION_INIT_BIT];   // [R14]
                    end
                    if (sync_bad) begin
                        state_next        = ST_ERROR;
                        status_drive_next = 1'b1;                      // [R16]
                        error_next        = 1'b1;
                    end else if (image_end) begin
                        state_next      = ST_INIT;
                        done_drive_next = 1'b0;                        // [R11]
                    end
                end
            end
            ST_ERROR: begin
                status_drive_next = 1'b1;                              // [R16]
            end
            ST_INIT: begin
                if (config_clock_fall) begin
                    fall_cnt_next = fall_cnt_reg + 2'h1;
                    if (fall_cnt_reg == 2'(INIT_FALL_EDGES - 1)) begin
                        state_next      = ST_USER;
                        init_drive_next = 1'b0;                        // [R14]
                        user_mode_next  = 1'b1;
                    end
                end
            end
            ST_USER: begin
                user_mode_next = 1'b1;
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
        // a low request restarts from any state once power-on is over
        if (state_reg != ST_POR && ncfg_low) begin
            state_next        = ST_CLEAR;                              // [R5]
            status_drive_next = 1'b1;
            done_drive_next   = 1'b1;
            init_drive_next   = 1'b0;
            user_mode_next    = 1'b0;
            word_valid_next   = 1'b0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg        <= ST_POR;
            por_cnt_reg      <= '0;
            ratio_reg        <= RATIO_PLAIN;
            mask_reg         <= MASK_W32;
            phase_reg        <= 4'h0;
            word_cnt_reg     <= '0;
            fall_cnt_reg     <= 2'h0;
            init_opt_reg     <= 1'b0;
            status_drive_reg <= 1'b1;
            done_drive_reg   <= 1'b1;
            init_drive_reg   <= 1'b0;
            word_data_reg    <= 32'h0000_0000;
            word_valid_reg   <= 1'b0;
            user_mode_reg    <= 1'b0;
            error_reg        <= 1'b0;
        end else begin
            state_reg        <= state_next;
            por_cnt_reg      <= por_cnt_next;
            ratio_reg        <= ratio_next;
            mask_reg         <= mask_next;
            phase_reg        <= phase_next;
            word_cnt_reg     <= word_cnt_next;
            fall_cnt_reg     <= fall_cnt_next;
            init_opt_reg     <= init_opt_next;
            status_drive_reg <= status_drive_next;
            done_drive_reg   <= done_drive_next;
            init_drive_reg   <= init_drive_next;
            word_data_reg    <= word_data_next;
            word_valid_reg   <= word_valid_next;
            user_mode_reg    <= user_mode_next;
            error_reg        <= error_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // open-drain lines only ever pull low; the pull-up gives the high
    assign link.status_n_o       = 1'b0;
    assign link.status_n_oe      = status_drive_reg;                   // [R6]
    assign link.done_o           = 1'b0;
    assign link.done_oe          = done_drive_reg;                     // [R7]
    assign link.init_complete_o  = 1'b0;
    assign link.init_complete_oe = init_drive_reg;                     // [R14]
    assign word_data             = word_data_reg;
    assign word_valid            = word_valid_reg;
    assign user_mode             = user_mode_reg;
    assign cfg_error             = error_reg;

endmodule // pcr_device

// ===== verilog/pcr_host.sv
// host end: makes config_clock by dividing core_clk and feeds the image
// word by word from a user-side lookup indexed by word_index.
// assumes word_in follows word_index within one core_clk cycle.
`timescale 1ns/10ps
module pcr_host #(
    parameter int IMAGE_WORDS = 16,
    parameter int HALF_CYCLES = pcr_pkg::LINK_HALF_CYCLES
) (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    pcr_link_if.host                    link,
    input  wire pcr_pkg::pcr_width_type width_sel,
    input  wire logic                   decomp_en,
    input  wire logic                   security_en,
    input  wire logic                   start,
    input  wire logic                   pause,
    input  wire logic [31:0]            word_in,
    output logic [$clog2(IMAGE_WORDS+1)-1:0] word_index,
    output logic                        busy,
    output logic                        finished,
    output logic                        failed
);
    import pcr_pkg::*;

    localparam int CW = $clog2(IMAGE_WORDS + 1);
    localparam int DW = $clog2(HALF_CYCLES + 1);

    typedef enum logic [2:0] {H_IDLE, H_RESET, H_WAIT_STATUS, H_SEND, H_WAIT_DONE, H_INIT,
                              H_FINISH} pcr_host_state_type;

    // ****************************************************************
    // pin synchronisers and link clock divider
    // ****************************************************************
    logic [1:0] stat_sync_reg;
    logic [1:0] done_sync_reg;
    logic [DW-1:0] div_reg;

    wire tick = (div_reg == DW'(HALF_CYCLES - 1));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stat_sync_reg <= 2'h0;
            done_sync_reg <= 2'h0;
            div_reg       <= '0;
        end else begin
            stat_sync_reg <= {stat_sync_reg[0], link.status_n};
            done_sync_reg <= {done_sync_reg[0], link.cfg_done};
            div_reg       <= tick ? '0 : div_reg + 1'b1;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    pcr_host_state_type state_reg;
    logic [$clog2(NCFG_LOW_CYCLES)-1:0] low_cnt_reg;
    logic          config_clock_reg;
    logic          ncfg_reg;
    logic [31:0]   data_reg;
    logic          load_reg;
    logic [3:0]    ratio_reg;
    logic [3:0]    phase_reg;
    logic [CW-1:0] index_reg;
    logic [1:0]    fall_cnt_reg;
    logic          failed_reg;

    wire group_end  = (phase_reg == ratio_reg - 4'h1);
    wire last_word  = (index_reg == CW'(IMAGE_WORDS - 1));
    wire rise_ok    = tick & ~config_clock_reg & ~pause & ~load_reg;            // [R8] [R9]
    wire fall_now   = tick & config_clock_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg    <= H_IDLE;
            low_cnt_reg  <= '0;
            config_clock_reg     <= 1'b0;
            ncfg_reg     <= 1'b1;
            data_reg     <= 32'h0000_0000;
            load_reg     <= 1'b0;
            ratio_reg    <= RATIO_PLAIN;
            phase_reg    <= 4'h0;
            index_reg    <= '0;
            fall_cnt_reg <= 2'h0;
            failed_reg   <= 1'b0;
        end else begin
            load_reg <= 1'b0;
            if (load_reg)
                data_reg <= word_in & lane_mask(width_sel);            // [R4]
            case (state_reg)
                H_IDLE: begin
                    if (start) begin
                        state_reg   <= H_RESET;
                        ncfg_reg    <= 1'b0;                           // [R5]
                        low_cnt_reg <= '0;
                        failed_reg  <= 1'b0;
                        ratio_reg   <= ratio_of(width_sel, decomp_en, security_en);
                    end
                end
                H_RESET: begin
                    low_cnt_reg <= low_cnt_reg + 1'b1;
                    if (low_cnt_reg == ($clog2(NCFG_LOW_CYCLES))'(NCFG_LOW_CYCLES - 1)) begin
                        state_reg <= H_WAIT_STATUS;
                        ncfg_reg  <= 1'b1;
                    end
                end
                H_WAIT_STATUS: begin
                    if (stat_sync_reg[1]) begin
                        state_reg <= H_SEND;
                        index_reg <= '0;
                        phase_reg <= 4'h0;
                        load_reg  <= 1'b1;
                    end
                end
                H_SEND: begin
                    if (!stat_sync_reg[1]) begin
                        state_reg  <= H_FINISH;
                        failed_reg <= 1'b1;
                        config_clock_reg   <= 1'b0;
                    end else if (rise_ok) begin
                        config_clock_reg <= 1'b1;
                    end else if (fall_now) begin
                        config_clock_reg  <= 1'b0;
                        phase_reg <= group_end ? 4'h0 : phase_reg + 4'h1; // [R2]
                        // a full group after the last word is its ratio-1 tail
                        if (group_end && last_word) begin
                            state_reg <= H_WAIT_DONE;                  // [R3] [R10]
                        end else if (group_end) begin
                            index_reg <= index_reg + 1'b1;
                            load_reg  <= 1'b1;                         // [R2]
                        end
                    end
                end
                H_WAIT_DONE: begin
                    if (done_sync_reg[1]) begin
                        state_reg    <= H_INIT;
                        fall_cnt_reg <= 2'h0;
                    end
                end
                H_INIT: begin
                    if (tick)
                        config_clock_reg <= ~config_clock_reg;
                    if (fall_now) begin
                        fall_cnt_reg <= fall_cnt_reg + 2'h1;           // [R12]
                        if (fall_cnt_reg == 2'(INIT_FALL_EDGES - 1))
                            state_reg <= H_FINISH;
                    end
                end
                H_FINISH: begin
                    config_clock_reg <= 1'b0;                                  // [R13]
                    if (start) begin
                        state_reg   <= H_RESET;
                        ncfg_reg    <= 1'b0;
                        low_cnt_reg <= '0;
                        failed_reg  <= 1'b0;
                        ratio_reg   <= ratio_of(width_sel, decomp_en, security_en);
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    assign link.config_clock   = config_clock_reg;                             // [R13]
    assign link.data           = data_reg;
    assign link.reconfig_req_n = ncfg_reg;
    assign word_index          = index_reg;
    // registered so both status outputs come straight from flip-flops
    logic busy_reg;
    logic finished_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_reg     <= 1'b0;
            finished_reg <= 1'b0;
        end else begin
            busy_reg     <= (state_reg != H_IDLE) && (state_reg != H_FINISH);
            finished_reg <= (state_reg == H_FINISH) && !failed_reg;
        end
    end

    assign busy                = busy_reg;
    assign finished            = finished_reg;
    assign failed              = failed_reg;

endmodule // pcr_host

// ===== verilog/pcr_link_if.sv
// the configuration link pins between host and device.
// assumes pull-ups on status, done and init lines; open-drain ends pull low.
`timescale 1ns/10ps
interface pcr_link_if;
    logic        config_clock;
    logic [31:0] data;
    logic        reconfig_req_n;
    logic        status_n_o;
    logic        status_n_oe;
    logic        done_o;
    logic        done_oe;
    logic        init_complete_o;
    logic        init_complete_oe;
    logic        status_n;
    logic        cfg_done;
    logic        init_complete;

    // pulled up unless the device drives
    assign status_n      = status_n_oe ? status_n_o : 1'b1;
    assign cfg_done      = done_oe ? done_o : 1'b1;
    assign init_complete = init_complete_oe ? init_complete_o : 1'b1;

    modport device (
        input  config_clock, data, reconfig_req_n,
        output status_n_o, status_n_oe, done_o, done_oe, init_complete_o, init_complete_oe,
        input  status_n, cfg_done, init_complete
    );
    modport host (
        output config_clock, data, reconfig_req_n,
        input  status_n, cfg_done, init_complete
    );
endinterface

// ===== verilog/pcr_pkg.sv
// constants, types and helper functions shared by both ends of the
// parallel configuration link.
// assumes a single 20 MHz core clock on each end.
//
// Overview of operation
// R1: word ratio 1, 4 secure, 8 decompressing
// R2: host clocks ratio times per word
// R3: host adds ratio-1 clocks after last word
// R4: narrow modes use low data lanes
// R5: user mode lines high; request low restarts
// R6: status held low through power-on delay
// R7: done held low until reception ends
// R8: host pauses only with clock low
// R9: data valid before resuming rising edge
// R10: host sends the whole image
// R11: done released after all words received
// R12: host gives two falling edges after done
// R13: host keeps driving clock after finish; the code holds config_clock low in H_FINISH
// R14: init pin low until init, if enabled
// R15: word sampled on first rising edge
// R16: status low flags reception error
package pcr_pkg;

    typedef enum logic [1:0] {PCR_W8, PCR_W16, PCR_W32} pcr_width_type;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 50;
    localparam int POR_TIME_NS     = 100000;
    localparam int POR_CYCLES      = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NCFG_LOW_NS     = 2000;
    localparam int NCFG_LOW_CYCLES = (NCFG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LINK_HALF_CYCLES = 4;
    localparam int INIT_FALL_EDGES = 2;

    // ****************************************************************
    // ratios, image layout, lanes
    // ****************************************************************
    localparam logic [3:0]  RATIO_PLAIN  = 4'h1;
    localparam logic [3:0]  RATIO_SECURE = 4'h4;
    localparam logic [3:0]  RATIO_DECOMP = 4'h8;
    localparam logic [31:0] SYNC_WORD    = 32'h5ac3_3ca5;
    localparam int          SYNC_WORD_IDX   = 0;
    localparam int          OPTION_WORD_IDX = 1;
    localparam int          OPTION_INIT_BIT = 0;
    localparam logic [31:0] MASK_W8  = 32'h0000_00ff;
    localparam logic [31:0] MASK_W16 = 32'h0000_ffff;
    localparam logic [31:0] MASK_W32 = 32'hffff_ffff;

    // clocks per word; only the 32-bit mode spends extra clocks
    function automatic logic [3:0] ratio_of(input pcr_width_type w, input logic decomp, input logic sec);
        if (w != PCR_W32)
            return RATIO_PLAIN;
        if (decomp)
            return RATIO_DECOMP;         // [R1]
        if (sec)
            return RATIO_SECURE;         // [R1]
        return RATIO_PLAIN;              // [R1]
    endfunction

    function automatic logic [31:0] lane_mask(input pcr_width_type w);
        case (w)
            PCR_W8:  return MASK_W8;
            PCR_W16: return MASK_W16;
            default: return MASK_W32;
        endcase
    endfunction

endpackage
